// *** design/pmcc_encoder.sv ***
/*
 Combinational result encoder: binary count to four BCD digits,
 leading digit code, overrange and overload flags.
 Assumes counts below 131072.
*/
`timescale 1ns/1ps
module pmcc_encoder
    import pmcc_pkg::*;
(
    // Sample link
    pmcc_sample_if.enc s
);
    logic [16:0] rem;
    logic [2:0]  lead_dig;
    logic [15:0] low4;
    logic        over1;
    logic        over4;

    // Leading digit, then four digits by repeated divide
    assign lead_dig = 3'(s.count / 17'd10000);
    assign rem      = s.count % 17'd10000;
    assign low4[3:0]   = 4'(rem % 17'd10);
    assign low4[7:4]   = 4'((rem / 17'd10) % 17'd10);
    assign low4[11:8]  = 4'((rem / 17'd100) % 17'd10);
    assign low4[15:12] = 4'(rem / 17'd1000);
    assign over1 = s.count > CNT_19999;
    assign over4 = s.count > CNT_39999;

    assign s.bcd = low4;
    assign s.lead = (s.range4 && !over4) ? lead_dig[1:0] : 2'b00;
    assign s.overrange = !s.range4 && !over1
                         && s.count >= CNT_10000;
    assign s.overload = s.range4 ? over4 : over1;
endmodule

// *** design/pmcc_pkg.sv ***
/*
 Package for the panel meter conversion control: register offsets,
 field positions, reset values, timing constants and state types.
 Assumes a 10 MHz core clock.
*/
package pmcc_pkg;
    // Core clock
    localparam int unsigned CLK_HZ          = 10_000_000;
    // Data valid delay after conversion end, in microseconds
    localparam int unsigned VALID_DLY_US    = 500;
    localparam int unsigned VALID_DLY_CYC   = VALID_DLY_US * (CLK_HZ / 1_000_000);
    // Least external start pulse width, in nanoseconds
    localparam int unsigned START_MIN_NS    = 100;
    localparam int unsigned START_MIN_CYC   =
        (START_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Internal start clock rate, pulses per second
    localparam int unsigned INT_START_HZ    = 2;
    localparam int unsigned INT_START_CYC   = CLK_HZ / INT_START_HZ;
    // Internal start pulse length in cycles
    localparam int unsigned INT_PULSE_CYC   = 4;
    // Overload blink half period, 4 Hz blink
    localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 8;
    // Default conversion length, cycles
    localparam int unsigned CONV_CYC        = 1_000_000;

    // Count limits
    localparam logic [16:0] CNT_10000 = 17'h02710;
    localparam logic [16:0] CNT_19999 = 17'h04e1f;
    localparam logic [16:0] CNT_39999 = 17'h09c3f;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STAT   = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h8;
    localparam logic [3:0] OFS_IRQ_ST = 4'hc;
    // Second page
    localparam logic [4:0] OFS_IRQ_CLR = 5'h10;
    localparam logic [4:0] OFS_IRQ_EN  = 5'h14;
    localparam logic [4:0] OFS_SAMPLE  = 5'h18;

    // Control fields
    localparam int unsigned CTRL_GATE   = 0;
    localparam int unsigned CTRL_RANGE  = 1;
    localparam int unsigned CTRL_START  = 2;
    localparam int unsigned CTRL_DP_LSB = 4;
    localparam logic [7:0]  CTRL_RST    = 8'h00;

    // Interrupt bits
    localparam int unsigned IRQ_DONE  = 0;
    localparam int unsigned IRQ_VALID = 1;
    localparam int unsigned IRQ_OVL   = 2;
    localparam int unsigned IRQ_W     = 3;

    localparam logic [31:0] BUS_UNMAPPED = 32'hdeadbeef;

    typedef enum logic [1:0]
    {
        PMCC_IDLE    = 2'b00,
        PMCC_CONVERT = 2'b01,
        PMCC_SETTLE  = 2'b11
    } pmcc_state_t;
endpackage

// *** design/pmcc_sample_if.sv ***
/*
 Interface carrying a finished sample from the converter front to
 the result encoder. Assumes one clock, core_clk.
*/
`timescale 1ns/1ps
interface pmcc_sample_if;
    logic [16:0] count;
    logic        positive;
    logic        range4;
    logic [15:0] bcd;
    logic [1:0]  lead;
    logic        overrange;
    logic        overload;

    modport src
    (
        output count,
        output positive,
        output range4,
        input  bcd,
        input  lead,
        input  overrange,
        input  overload
    );
    modport enc
    (
        input  count,
        input  positive,
        input  range4,
        output bcd,
        output lead,
        output overrange,
        output overload
    );
endinterface

// *** design/pmcc_start_clock.sv ***
/*
 Internal start clock: gated divider giving short positive start
 pulses at two per second. Assumes a 10 MHz core clock.
*/
`timescale 1ns/1ps
module pmcc_start_clock
    import pmcc_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = INT_START_CYC
)
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Control
    input  wire logic gate,
    // Pulse out
    output logic      pulse
);
    logic [31:0] div_ff;
    logic [31:0] nxt_div;
    logic        wrap;

    assign wrap    = div_ff == 32'(PERIOD_CYC - 1);
    // Stopped gate clears the phase, so restart begins with a pulse
    assign nxt_div = !gate ? '0 : (wrap ? '0 : div_ff + 32'd1);
    assign pulse   = gate && div_ff < 32'(INT_PULSE_CYC);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            div_ff <= '0;
        else
            div_ff <= nxt_div;
    end
endmodule

// *** design/pmcc_top.sv ***
/*
 Panel meter conversion control top: start sequencing, result
 latching, overload blink, Avalon-MM register slave and interrupt.
 Assumes synchronous inputs on core_clk; count comes from the
 dual-slope counter as a binary value with its polarity.
*/
// Chosen here: the Avalon-MM register port and the placing of the registers.
// Contract
// - Result is sixteen parallel BCD lines, 8-4-2-1, positive true.
// - Low range: overrange high for 10000..19999, overload low.
// - High range: leading digit 1..3 as two-bit binary, overload low.
// - Polarity high for positive input, low for negative.
// - Low range: overload high above 19999, low otherwise.
// - High range: overload high above 39999, low otherwise.
// - Conversion-active high through conversion; outputs invalid.
// - Data valid 500 us after conversion-active falls.
// - Conversion begins at the falling edge of the start pulse.
// - Internal start clock runs while gate high, stops when low; with the CTRL_GATE bit set it keeps running while start_gate is low.
// - Internal start clock gives two pulses per second.
// - Overload blinks centre bars of sign and four low digits.
// - Decimal point lit when its select input is grounded.
`timescale 1ns/1ps
module pmcc_top
    import pmcc_pkg::*;
#(
    parameter int unsigned VALID_CYC  = VALID_DLY_CYC,
    parameter int unsigned PERIOD_CYC = INT_START_CYC,
    parameter int unsigned BLINK_CYC  = BLINK_HALF_CYC
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Start control
    input  wire logic        ext_start,
    input  wire logic        start_gate,
    output logic             int_start_out,
    // Counter front end
    input  wire logic [16:0] meas_count,
    input  wire logic        meas_positive,
    input  wire logic        meas_done,
    // Decimal point selects, active low
    input  wire logic [3:0]  dp_sel_n,
    // Results
    output logic [15:0]      bcd_out,
    output logic [1:0]       lead_out,
    output logic             overrange_out,
    output logic             overload_out,
    output logic             polarity_out,
    output logic             conv_active,
    output logic             data_valid,
    // Display control
    output logic [4:0]       center_bar,
    output logic [3:0]       dp_lit,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq
);
    pmcc_sample_if smp();

    pmcc_state_t       state_ff;
    pmcc_state_t       nxt_state;
    logic              ext_q_ff;
    logic              int_q_ff;
    logic [31:0]       settle_ff;
    logic [16:0]       cnt_ff;
    logic              pos_ff;
    logic [15:0]       bcd_ff;
    logic [1:0]        lead_ff;
    logic              ovr_ff;
    logic              ovl_ff;
    logic              pol_ff;
    logic              valid_ff;
    logic [31:0]       blink_cnt_ff;
    logic              blink_ff;
    logic [7:0]        ctrl_ff;
    logic [IRQ_W-1:0]  irq_st_ff;
    logic [IRQ_W-1:0]  irq_en_ff;
    logic              ack_ff;
    logic [31:0]       rdata_ff;

    logic              int_pulse;
    logic              gate_run;
    logic              ext_fall;
    logic              int_fall;
    logic              sw_start;
    logic              start_req;
    logic              start_take;
    logic              settle_end;
    logic              blink_wrap;
    logic              bus_req;
    logic              wr_acc;
    logic              rd_acc;
    logic [IRQ_W-1:0]  irq_ev;
    logic [IRQ_W-1:0]  irq_clr;
    logic [31:0]       rd_mux;

    // Internal start clock
    assign gate_run = start_gate | ctrl_ff[CTRL_GATE];
    pmcc_start_clock #(.PERIOD_CYC(PERIOD_CYC)) u_sclk
    (
        .core_clk (core_clk),
        .rst      (rst),
        .gate     (gate_run),
        .pulse    (int_pulse)
    );
    assign int_start_out = int_pulse;

    // Start detection on falling edges of ext_start and int_pulse, or a CTRL_START write
    assign ext_fall  = ext_q_ff && !ext_start;
    assign int_fall  = int_q_ff && !int_pulse;
    assign sw_start  = wr_acc && avs_address == {1'b0, OFS_CTRL}
                       && avs_writedata[CTRL_START];
    assign start_req = ext_fall | int_fall | sw_start;
    // A request mid-conversion is dropped, not queued
    assign start_take = start_req && state_ff != PMCC_CONVERT;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ext_q_ff <= 1'b0;
            int_q_ff <= 1'b0;
        end
        else
        begin
            ext_q_ff <= ext_start;
            int_q_ff <= int_pulse;
        end
    end

    // Conversion sequencer
    assign settle_end = state_ff == PMCC_SETTLE
                        && settle_ff == 32'(VALID_CYC - 1);
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            PMCC_IDLE:    if (start_take) nxt_state = PMCC_CONVERT;
            PMCC_CONVERT: if (meas_done) nxt_state = PMCC_SETTLE;
            PMCC_SETTLE:
                if (start_take) nxt_state = PMCC_CONVERT;
                else if (settle_end) nxt_state = PMCC_IDLE;
            default:      nxt_state = PMCC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff  <= PMCC_IDLE;
            settle_ff <= '0;
        end
        else
        begin
            state_ff  <= nxt_state;
            settle_ff <= state_ff == PMCC_SETTLE ? settle_ff + 32'd1 : '0;
        end
    end
    assign conv_active = state_ff == PMCC_CONVERT;

    // Sample capture at the end of conversion
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff <= '0;
            pos_ff <= 1'b0;
        end
        else if (state_ff == PMCC_CONVERT && meas_done)
        begin
            cnt_ff <= meas_count;
            pos_ff <= meas_positive;
        end
    end

    assign smp.count    = cnt_ff;
    assign smp.positive = pos_ff;
    assign smp.range4   = ctrl_ff[CTRL_RANGE];
    pmcc_encoder u_enc
    (
        .s (smp.enc)
    );

    // Output latch: loads at data valid, holds through the next conversion
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bcd_ff   <= '0;
            lead_ff  <= '0;
            ovr_ff   <= 1'b0;
            ovl_ff   <= 1'b0;
            pol_ff   <= 1'b0;
            valid_ff <= 1'b0;
        end
        else if (start_take)
            valid_ff <= 1'b0;
        else if (settle_end)
        begin
            bcd_ff   <= smp.bcd;
            lead_ff  <= smp.lead;
            ovr_ff   <= smp.overrange;
            ovl_ff   <= smp.overload;
            pol_ff   <= smp.positive;
            valid_ff <= 1'b1;
        end
    end
    assign bcd_out       = bcd_ff;
    assign lead_out      = lead_ff;
    assign overrange_out = ovr_ff;
    assign overload_out  = ovl_ff;
    assign polarity_out  = pol_ff;
    assign data_valid    = valid_ff;

    // Overload blink of centre bars
    assign blink_wrap = blink_cnt_ff == 32'(BLINK_CYC - 1);
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            blink_cnt_ff <= '0;
            blink_ff     <= 1'b0;
        end
        else
        begin
            blink_cnt_ff <= blink_wrap ? '0 : blink_cnt_ff + 32'd1;
            blink_ff     <= blink_wrap ? !blink_ff : blink_ff;
        end
    end
    assign center_bar = (ovl_ff && blink_ff) ? 5'h1f : 5'h00;
    assign dp_lit     = ~dp_sel_n | ctrl_ff[CTRL_DP_LSB +: 4];

    // Avalon-MM slave, one wait state on each access
    assign bus_req = (avs_read | avs_write) && !ack_ff;
    assign wr_acc  = avs_write && ack_ff;
    assign rd_acc  = avs_read && ack_ff;
    assign avs_waitrequest = (avs_read | avs_write) && !ack_ff;

    assign rd_mux =
        avs_address == {1'b0, OFS_CTRL}   ? {24'h000000, ctrl_ff} :
        avs_address == {1'b0, OFS_STAT}   ?
            {28'h0000000, valid_ff, state_ff, conv_active} :
        avs_address == {1'b0, OFS_RESULT} ?
            {9'h000, pol_ff, ovl_ff, ovr_ff, lead_ff, 2'b00, bcd_ff} :
        avs_address == {1'b0, OFS_IRQ_ST} ? 32'(irq_st_ff) :
        avs_address == OFS_IRQ_CLR        ? 32'h00000000 :
        avs_address == OFS_IRQ_EN         ? 32'(irq_en_ff) :
        avs_address == OFS_SAMPLE         ?
            {14'h0000, pos_ff, cnt_ff} : BUS_UNMAPPED;

    // Interrupt events, set wins over clear
    assign irq_ev[IRQ_DONE]  = state_ff == PMCC_CONVERT && meas_done;
    assign irq_ev[IRQ_VALID] = settle_end && !start_take;
    assign irq_ev[IRQ_OVL]   = settle_end && !start_take && smp.overload;
    assign irq_clr = (wr_acc && avs_address == OFS_IRQ_CLR)
                     ? avs_writedata[IRQ_W-1:0] : '0;
    assign irq = |(irq_st_ff & irq_en_ff);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_ff    <= 1'b0;
            rdata_ff  <= '0;
            ctrl_ff   <= CTRL_RST;
            irq_st_ff <= '0;
            irq_en_ff <= '0;
        end
        else
        begin
            ack_ff    <= bus_req;
            rdata_ff  <= bus_req ? rd_mux : rdata_ff;
            irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_ev;
            if (wr_acc && avs_address == {1'b0, OFS_CTRL})
                ctrl_ff <= {avs_writedata[7:3], 1'b0, avs_writedata[1:0]};
            if (wr_acc && avs_address == OFS_IRQ_EN)
                irq_en_ff <= avs_writedata[IRQ_W-1:0];
        end
    end
    assign avs_readdata = rd_acc ? rdata_ff : 32'h00000000;

    // BCD and overload outputs hold steady while data is valid
    a_hold_result: assert property (
        @(posedge core_clk) disable iff (rst)
        valid_ff && $past(valid_ff) |-> $stable(bcd_ff) && $stable(ovl_ff))
        else $error("result changed while valid");

    // Valid rises exactly after the settle delay
    a_valid_delay: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(valid_ff) |-> $past(settle_ff) == 32'(VALID_CYC - 1))
        else $error("data valid early");

    // Falling trigger edge starts conversion next cycle
    a_ext_start: assert property (
        @(posedge core_clk) disable iff (rst)
        ext_fall && state_ff == PMCC_IDLE |=> conv_active)
        else $error("falling start edge missed");

    // Busy ignores new starts
    a_busy_ignore: assert property (
        @(posedge core_clk) disable iff (rst)
        conv_active && !meas_done |=> conv_active && !valid_ff)
        else $error("start taken while busy");

    a_conv_end: assert property (
        @(posedge core_clk) disable iff (rst)
        conv_active && meas_done |=> !conv_active)
        else $error("conversion not ended");

    // Valid never high in conversion
    a_busy_invalid: assert property (
        @(posedge core_clk) disable iff (rst)
        conv_active |-> !valid_ff)
        else $error("valid during conversion");

    // Overrange and overload exclusive, low range only
    a_ovr_range: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(valid_ff) && overrange_out |->
            !overload_out && !$past(ctrl_ff[CTRL_RANGE]))
        else $error("overrange with overload");

    // Overload matches count limit of the range
    a_ovl_limit: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(valid_ff) |-> ovl_ff == ($past(ctrl_ff[CTRL_RANGE]) ?
            cnt_ff > CNT_39999 : cnt_ff > CNT_19999))
        else $error("overload flag wrong");

    // Blink only under overload
    a_blink_ovl: assert property (
        @(posedge core_clk) disable iff (rst)
        center_bar != 5'h00 |-> ovl_ff)
        else $error("blink without overload");

    // Stopped start clock gives no pulse
    a_gate_stop: assert property (
        @(posedge core_clk) disable iff (rst)
        !gate_run |-> !int_start_out)
        else $error("start pulse while gated off");
endmodule

// *** verif/panel_meter_conversion_control_test.sv ***
/*
 Self-checking bench for the conversion control top.
 Assumes pmcc_pkg, the sample interface and the front-end model.
*/
`timescale 1ns/1ps
module panel_meter_conversion_control_test
    import pmcc_pkg::*;
;
    localparam int VCYC = 20;
    localparam logic [4:0] A_CTRL = {1'b0, OFS_CTRL};
    localparam logic [4:0] A_IRQ  = {1'b0, OFS_IRQ_ST};
    typedef struct packed
    {
        logic [15:0] bcd;
        logic [1:0]  lead;
        logic        ovr;
        logic        ovl;
        logic        pol;
    } pmcc_exp_t;

    logic        core_clk      = 1'b0;
    logic        rst           = 1'b1;
    logic        ext_start     = 1'b0;
    logic        start_gate    = 1'b0;
    logic [3:0]  dp_sel_n      = 4'hf;
    logic [4:0]  avs_address   = 5'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [7:0]  conv_len      = 8'h06;
    logic [16:0] count_in      = 17'h0;
    logic        pos_in        = 1'b0;
    logic        hi            = 1'b0;
    logic [16:0] meas_count;
    logic        meas_positive, meas_done, int_start_out;
    logic [15:0] bcd_out;
    logic [1:0]  lead_out;
    logic        overrange_out, overload_out, polarity_out;
    logic        conv_active, data_valid, avs_waitrequest, irq;
    logic [4:0]  center_bar;
    logic [3:0]  dp_lit;
    logic [31:0] avs_readdata;
    int          n_fail    = 0;
    int          tests_run = 0;
    int          cyc       = 0;
    int          since     = 0;
    pmcc_exp_t   q[$];
    logic [16:0] lo_tab[6] = '{17'h00000, 17'h0270f, CNT_10000,
                               CNT_19999, 17'h04e20, 17'h1ffff};
    logic [16:0] hi_tab[4] = '{CNT_10000, 17'h0752f, CNT_39999, 17'h09c40};

    pmcc_top #(.VALID_CYC(VCYC), .PERIOD_CYC(64), .BLINK_CYC(8)) dut
    (
        .core_clk        (core_clk),
        .rst             (rst),
        .ext_start       (ext_start),
        .start_gate      (start_gate),
        .int_start_out   (int_start_out),
        .meas_count      (meas_count),
        .meas_positive   (meas_positive),
        .meas_done       (meas_done),
        .dp_sel_n        (dp_sel_n),
        .bcd_out         (bcd_out),
        .lead_out        (lead_out),
        .overrange_out   (overrange_out),
        .overload_out    (overload_out),
        .polarity_out    (polarity_out),
        .conv_active     (conv_active),
        .data_valid      (data_valid),
        .center_bar      (center_bar),
        .dp_lit          (dp_lit),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .irq             (irq)
    );

    pmcc_front_model front
    (
        .core_clk      (core_clk),
        .rst           (rst),
        .conv_len      (conv_len),
        .count_in      (count_in),
        .pos_in        (pos_in),
        .conv_active   (conv_active),
        .meas_count    (meas_count),
        .meas_positive (meas_positive),
        .meas_done     (meas_done)
    );

    initial
    begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic end_sim();
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            n_fail++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    // Read compares masked data; a write ignores d as expectation
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, input logic [31:0] mask);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        chk(n == 2, "wait state");
        if (!wr)
            chk((avs_readdata & mask) === (d & mask), "read data");
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    function automatic pmcc_exp_t exp_of(input logic [16:0] c,
                                         input logic p, input logic h);
        pmcc_exp_t e;
        int v;
        v = int'(c) % 10000;
        e.bcd  = {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10),
                  4'(v % 10)};
        e.ovl  = h ? (c > CNT_39999) : (c > CNT_19999);
        e.ovr  = !h && c >= CNT_10000 && !e.ovl;
        e.lead = (h && !e.ovl) ? 2'(int'(c) / 10000) : 2'h0;
        e.pol  = p;
        return e;
    endfunction

    // Mode 0 pin start, 1 pin start twice, 2 register start
    task automatic conv(input logic [16:0] c, input logic p,
                        input int len, input int mode);
        int n;
        count_in <= c;
        pos_in   <= p;
        conv_len <= 8'(len);
        q.push_back(exp_of(c, p, hi));
        if (mode == 2)
            bus(1'b1, A_CTRL, 32'h4, 32'h0);
        else
        begin
            @(posedge core_clk);
            ext_start <= 1'b1;
            @(posedge core_clk);
            ext_start <= 1'b0;
        end
        repeat (2) @(posedge core_clk);
        chk(conv_active === 1'b1 && data_valid === 1'b0, "start");
        if (mode == 2)
            bus(1'b0, A_CTRL, 32'h0, 32'h4);
        if (mode == 1)
        begin
            ext_start <= 1'b1;
            @(posedge core_clk);
            ext_start <= 1'b0;
        end
        n = 0;
        while (data_valid !== 1'b1)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(n < 400, "no result");
        repeat (2) @(posedge core_clk);
    endtask

    task automatic watch_bar(input logic want);
        int on, off, bad;
        on = 0;
        off = 0;
        bad = 0;
        repeat (40)
        begin
            @(posedge core_clk);
            if (center_bar === 5'h1f)
                on++;
            else if (center_bar === 5'h00)
                off++;
            else
                bad++;
        end
        chk(bad == 0 && (on > 0) == want && off > 0, "blink");
    endtask

    // Result watcher, the reading party samples only at data valid
    pmcc_exp_t e, cur, res_q;
    logic      dv_q = 1'b0;
    logic      ca_q = 1'b0;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 40000)
        begin
            n_fail++;
            end_sim();
        end
        cur = '{bcd_out, lead_out, overrange_out, overload_out, polarity_out};
        since++;
        if (ca_q && conv_active === 1'b0)
            since = 0;
        if (data_valid === 1'b1 && !dv_q)
        begin
            chk(q.size() > 0, "extra result");
            chk(since == VCYC, "valid delay");
            if (q.size() > 0)
            begin
                e = q.pop_front();
                chk(cur === e, "result");
            end
        end
        if (data_valid === 1'b1 && dv_q)
            chk(cur === res_q, "result moved");
        res_q = cur;
        dv_q  = data_valid === 1'b1;
        ca_q  = conv_active === 1'b1;
    end

    initial
    begin
        int n;
        logic pr;
        void'($urandom(54039));
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        bus(1'b0, A_CTRL, 32'h0, 32'hff);
        bus(1'b0, OFS_IRQ_EN, 32'h0, 32'h7);
        bus(1'b1, 5'h1c, 32'hffffffff, 32'h0);
        bus(1'b0, 5'h1c, BUS_UNMAPPED, 32'hffffffff);
        bus(1'b1, OFS_IRQ_EN, 32'h7, 32'h0);
        foreach (lo_tab[i])
            conv(lo_tab[i], 1'(i), 6, 0);
        watch_bar(1'b1);
        chk(irq === 1'b1, "irq level");
        bus(1'b0, A_IRQ, 32'h7, 32'h7);
        bus(1'b1, OFS_IRQ_CLR, 32'h7, 32'h0);
        bus(1'b0, A_IRQ, 32'h0, 32'h7);
        chk(irq === 1'b0, "irq clear");
        bus(1'b1, OFS_IRQ_EN, 32'h0, 32'h0);
        conv(17'h01234, 1'b1, 3, 2);
        watch_bar(1'b0);
        chk(irq === 1'b0, "irq mask");
        bus(1'b0, A_IRQ, 32'h3, 32'h7);
        bus(1'b0, {1'b0, OFS_RESULT}, 32'h00404660, 32'hffffffff);
        conv(17'h00999, 1'b0, 30, 1);
        repeat (6)
            conv(17'($urandom_range(0, 19999)), 1'($urandom), 
                 $urandom_range(2, 20), 0);
        bus(1'b1, A_CTRL, 32'h2, 32'h0);
        bus(1'b0, A_CTRL, 32'h2, 32'hff);
        hi = 1'b1;
        foreach (hi_tab[i])
            conv(hi_tab[i], 1'(i), 6, 0);
        repeat (4)
            conv(17'($urandom_range(0, 45000)), 1'($urandom), 5, 0);
        bus(1'b1, A_CTRL, 32'h50, 32'h0);
        @(posedge core_clk);
        chk(dp_lit === 4'h5, "dp force");
        bus(1'b1, A_CTRL, 32'h0, 32'h0);
        hi = 1'b0;
        repeat (4)
        begin
            dp_sel_n <= 4'($urandom);
            repeat (2) @(posedge core_clk);
            chk(dp_lit === ~dp_sel_n, "dp select");
        end
        count_in <= 17'h01234;
        pos_in   <= 1'b1;
        conv_len <= 8'h08;
        repeat (4) q.push_back(exp_of(17'h01234, 1'b1, 1'b0));
        start_gate <= 1'b1;
        n = 0;
        pr = 1'b0;
        repeat (256)
        begin
            @(posedge core_clk);
            n += int'(int_start_out === 1'b1 && !pr);
            pr = int_start_out === 1'b1;
        end
        start_gate <= 1'b0;
        chk(n == 4, "start rate");
        n = 0;
        repeat (200)
        begin
            @(posedge core_clk);
            n += int'(int_start_out !== 1'b0);
        end
        chk(n == 0, "gate hold");
        chk(q.size() == 0, "missed start");
        end_sim();
    end
endmodule

// *** verif/pmcc_front_model.sv ***
/*
 Front-end counter model: ends each conversion with a count.
 Assumes conv_active from the block and one clock, core_clk.
*/
`timescale 1ns/1ps
module pmcc_front_model
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Bench settings
    input  wire logic [7:0]  conv_len,
    input  wire logic [16:0] count_in,
    input  wire logic        pos_in,
    // Block side
    input  wire logic        conv_active,
    output logic [16:0]      meas_count,
    output logic             meas_positive,
    output logic             meas_done
);
    logic [7:0] run_ff;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            run_ff        <= 8'h00;
            meas_done     <= 1'b0;
            meas_count    <= 17'h00000;
            meas_positive <= 1'b0;
        end
        else
        begin
            // Lines wiggle outside the done pulse, never hold a count
            meas_done     <= 1'b0;
            meas_count    <= ~meas_count;
            meas_positive <= ~meas_positive;
            run_ff        <= conv_active ? run_ff + 8'h01 : 8'h00;
            if (conv_active && run_ff == conv_len)
            begin
                meas_done     <= 1'b1;
                meas_count    <= count_in;
                meas_positive <= pos_in;
            end
        end
    end
endmodule
